// ===== rtl/rcr_pkg.sv
package rcr_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] RCR_OFS_STATUS = 8'h00;
  localparam logic [7:0] RCR_OFS_CAUSE0 = 8'h04;
  localparam logic [7:0] RCR_OFS_CAUSE1 = 8'h08;
  localparam logic [7:0] RCR_OFS_BORCTL = 8'h0C;

  // register selector decoded from the address
  typedef enum {
    RCR_SEL_STATUS,
    RCR_SEL_CAUSE0,
    RCR_SEL_CAUSE1,
    RCR_SEL_BORCTL,
    RCR_SEL_NONE
  } rcr_sel_t;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int RCR_ST_TIMEOUT = 4;
  localparam int RCR_ST_PDOWN = 3;
  localparam int RCR_C0_STKOVF = 7;
  localparam int RCR_C0_STUNF = 6;
  localparam int RCR_C0_WINV = 5;
  localparam int RCR_C0_WDT = 4;
  localparam int RCR_C0_EXTPIN = 3;
  localparam int RCR_C0_RSTINS = 2;
  localparam int RCR_C0_POR = 1;
  localparam int RCR_C0_BOR = 0;
  localparam int RCR_C1_MEMVIO = 1;
  localparam int RCR_BC_SWEN = 7;
  localparam int RCR_BC_RDY = 0;

  // ----------------------------------------------------------------
  // reset values and vectors
  // ----------------------------------------------------------------
  localparam logic RCR_TIMEOUT_RST = 1'b1;
  localparam logic RCR_PDOWN_RST = 1'b1;
  localparam logic [7:0] RCR_CAUSE0_RST = 8'h3C;
  localparam logic RCR_MEMVIO_RST = 1'b1;
  localparam logic RCR_SWEN_RST = 1'b1;
  localparam logic [1:0] RCR_BORCFG_SW = 2'h1;
  localparam logic [1:0] RCR_BORCFG_OFF = 2'h0;
  localparam int RCR_PC_W = 15;
  localparam logic [RCR_PC_W-1:0] RCR_RESET_VECTOR = 15'h0000;
  localparam logic [RCR_PC_W-1:0] RCR_IRQ_VECTOR = 15'h0004;

endpackage

// ===== rtl/rcr_apb_port.sv
`timescale 1ns/100ps
// ------------------------------------------------------------------
// apb decode: zero wait states, error on unmapped address
// ------------------------------------------------------------------
module rcr_apb_port (
  input wire logic psel, // slave select
  input wire logic penable, // access phase
  input wire logic pwrite, // write direction
  input wire logic [7:0] paddr, // byte address
  output logic pready, // always ready
  output logic pslverr, // unmapped access
  output logic wr_en, // write strobe in access phase
  output logic setup, // setup phase of any transfer
  output rcr_pkg::rcr_sel_t sel // selected register
);
  import rcr_pkg::*;

  // address decode
  always_comb begin
    unique case (paddr)
      RCR_OFS_STATUS: sel = RCR_SEL_STATUS;
      RCR_OFS_CAUSE0: sel = RCR_SEL_CAUSE0;
      RCR_OFS_CAUSE1: sel = RCR_SEL_CAUSE1;
      RCR_OFS_BORCTL: sel = RCR_SEL_BORCTL;
      default: sel = RCR_SEL_NONE;
    endcase
  end

  // handshake terms
  assign pready = 1'b1;
  assign pslverr = psel && penable && (sel == RCR_SEL_NONE);
  assign wr_en = psel && penable && pwrite && (sel != RCR_SEL_NONE);
  assign setup = psel && !penable;

endmodule // rcr_apb_port

// ===== rtl/rcr_reset_cause_recorder.sv
`timescale 1ns/100ps
// Operation
// - a reset event updates cause flags in status and cause registers so software can tell what happened; of events in one cycle only the highest-priority one does.
// - power-on sets timeout and power-down, clears power-on, brown-out and stack flags, sets the rest; cause 0 reads 0011 1100.
// - power-down reads set after power-on; a sleep wake or a pin reset in sleep clears it while power-on stays cleared.
// - external pin reset while running clears the pin flag, sets the memory violation flag and loads the program counter with 0000h.
// - external pin reset while sleeping clears the pin flag, sets timeout, clears power-down, restarts at the vector.
// - watchdog expiry while sleeping wakes without reset, clears timeout and power-down, continues after sleep.
// - interrupt wake from sleep sets timeout, clears power-down, keeps other flags and resumes at the next instruction.
// - interrupt wake with global enable runs the next instruction, pushes the return address and vectors to 0004h.
// - with stack fault reset enabled, overflow resets, sets the overflow flag only and restarts at 0000h.
// - with stack fault reset enabled, underflow resets and sets the underflow flag only.
// - with brown-out field not 01 the software enable stays read/write but does not affect brown-out reset.
// - with brown-out field 01 the software enable turns brown-out reset on or off; it resets to one.
// - the brown-out ready bit reads one while the detector is active and zero while inactive.
module rcr_reset_cause_recorder #(
  parameter int PC_W = rcr_pkg::RCR_PC_W // program counter width
) (
  input wire logic pclk, // core clock
  input wire logic presetn, // power-on reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic sleeping, // core is in sleep
  input wire logic ext_pin_event, // external reset pin asserted
  input wire logic brownout_detect, // supply below brown-out level
  input wire logic brownout_circuit_active, // brown-out detector running
  input wire logic [1:0] brownout_config_field, // configuration word field
  input wire logic wdt_expire_event, // watchdog timeout
  input wire logic wdt_window_event, // watchdog window violation
  input wire logic reset_instr_event, // reset instruction executed
  input wire logic stack_overflow_event, // stack overflow
  input wire logic stack_underflow_event, // stack underflow
  input wire logic stack_fault_reset_enable, // stack faults cause reset
  input wire logic mem_violation_event, // memory violation
  input wire logic interrupt_wake_event, // enabled interrupt while asleep
  input wire logic global_interrupt_enable, // global interrupt enable
  input wire logic [PC_W-1:0] pc_current, // address of current instruction
  output logic core_reset, // one-cycle core reset pulse
  output logic wake, // one-cycle wake pulse
  output logic pc_load, // one-cycle program counter load
  output logic [PC_W-1:0] pc_value, // program counter load value
  output logic stack_push, // one-cycle return address push
  output logic [PC_W-1:0] stack_push_addr, // return address
  output logic brownout_reset_enable // brown-out reset armed
);
  import rcr_pkg::*;

  // ----------------------------------------------------------------
  // bus port
  // ----------------------------------------------------------------
  logic wr_en;
  logic setup;
  rcr_sel_t sel;

  rcr_apb_port u_port (
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pready(pready),
    .pslverr(pslverr),
    .wr_en(wr_en),
    .setup(setup),
    .sel(sel)
  );

  // ----------------------------------------------------------------
  // flag state
  // ----------------------------------------------------------------
  logic timeout_reg;
  logic timeout_next;
  logic pdown_reg;
  logic pdown_next;
  logic [7:0] cause0_reg;
  logic [7:0] cause0_next;
  logic memvio_reg;
  logic memvio_next;
  logic swen_reg;
  logic swen_next;
  logic bor_fire;
  logic ovf_fire;
  logic unf_fire;
  logic wdt_wake;
  logic wdt_reset;
  logic irq_wake;
  logic any_reset;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // write strobe aimed at one register
  function automatic logic wr_hit(input logic strobe, input rcr_sel_t cur, input rcr_sel_t target);
    return strobe && (cur == target);
  endfunction

  // program counter advanced by a small step, wrapping at the counter width
  function automatic logic [PC_W-1:0] pc_step(input logic [PC_W-1:0] base, input logic [1:0] step);
    return base + PC_W'(step);
  endfunction

  // brown-out arming from configuration and software enable
  // software enable gates only with field 01
  assign brownout_reset_enable = (brownout_config_field == RCR_BORCFG_SW) ? swen_reg :
                                 (brownout_config_field != RCR_BORCFG_OFF);

  // qualified events
  assign bor_fire = brownout_detect && brownout_reset_enable;
  assign ovf_fire = stack_overflow_event && stack_fault_reset_enable;
  assign unf_fire = stack_underflow_event && stack_fault_reset_enable;
  assign wdt_wake = wdt_expire_event && sleeping;
  assign wdt_reset = wdt_expire_event && !sleeping;
  assign irq_wake = interrupt_wake_event && sleeping;
  assign any_reset = bor_fire || ext_pin_event || wdt_reset || wdt_window_event || reset_instr_event ||
                     ovf_fire || unf_fire || mem_violation_event;

  // next flag values: software write first, hardware event on top
  always_comb begin
    timeout_next = timeout_reg;
    pdown_next = pdown_reg;
    cause0_next = cause0_reg;
    memvio_next = memvio_reg;
    swen_next = swen_reg;
    if (wr_hit(wr_en, sel, RCR_SEL_CAUSE0)) begin
      cause0_next = pwdata[7:0];
    end
    if (wr_hit(wr_en, sel, RCR_SEL_CAUSE1)) begin
      memvio_next = pwdata[RCR_C1_MEMVIO];
    end
    if (wr_hit(wr_en, sel, RCR_SEL_BORCTL)) begin
      swen_next = pwdata[RCR_BC_SWEN];
    end
    if (bor_fire) begin
      // brown-out: power-on pattern, power-on flag kept
      timeout_next = 1'b1;
      pdown_next = 1'b1;
      cause0_next[RCR_C0_STKOVF] = 1'b0;
      cause0_next[RCR_C0_STUNF] = 1'b0;
      cause0_next[RCR_C0_WINV] = 1'b1;
      cause0_next[RCR_C0_WDT] = 1'b1;
      cause0_next[RCR_C0_EXTPIN] = 1'b1;
      cause0_next[RCR_C0_RSTINS] = 1'b1;
      cause0_next[RCR_C0_BOR] = 1'b0;
    end else if (ext_pin_event && !sleeping) begin
      cause0_next[RCR_C0_EXTPIN] = 1'b0;
      memvio_next = 1'b1;
    end else if (ext_pin_event) begin
      cause0_next[RCR_C0_EXTPIN] = 1'b0;
      timeout_next = 1'b1;
      pdown_next = 1'b0;
    end else if (wdt_reset) begin
      // watchdog reset while running
      timeout_next = 1'b0;
      cause0_next[RCR_C0_WDT] = 1'b0;
    end else if (wdt_wake) begin
      timeout_next = 1'b0;
      pdown_next = 1'b0;
    end else if (wdt_window_event) begin
      // window violation reset
      cause0_next[RCR_C0_WINV] = 1'b0;
    end else if (reset_instr_event) begin
      // reset instruction
      cause0_next[RCR_C0_RSTINS] = 1'b0;
    end else if (ovf_fire) begin
      cause0_next[RCR_C0_STKOVF] = 1'b1;
    end else if (unf_fire) begin
      cause0_next[RCR_C0_STUNF] = 1'b1;
    end else if (mem_violation_event) begin
      // memory violation clears its flag
      memvio_next = 1'b0;
    end else if (irq_wake) begin
      timeout_next = 1'b1;
      pdown_next = 1'b0;
    end
  end

  // status flags
  // power-on values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_reg <= RCR_TIMEOUT_RST;
      pdown_reg <= RCR_PDOWN_RST;
    end else begin
      timeout_reg <= timeout_next;
      pdown_reg <= pdown_next;
    end
  end

  // cause flags
  // cause register power-on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause0_reg <= RCR_CAUSE0_RST;
      memvio_reg <= RCR_MEMVIO_RST;
    end else begin
      cause0_reg <= cause0_next;
      memvio_reg <= memvio_next;
    end
  end

  // software brown-out enable
  // resets to one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swen_reg <= RCR_SWEN_RST;
    end else begin
      swen_reg <= swen_next;
    end
  end

  // ----------------------------------------------------------------
  // program counter and wake control
  // ----------------------------------------------------------------
  logic vector_pend_reg;
  logic [PC_W-1:0] ret_addr_reg;

  // reset and wake sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_reset <= 1'b0;
      wake <= 1'b0;
      pc_load <= 1'b0;
      pc_value <= RCR_RESET_VECTOR;
      stack_push <= 1'b0;
      stack_push_addr <= RCR_RESET_VECTOR;
      vector_pend_reg <= 1'b0;
      ret_addr_reg <= RCR_RESET_VECTOR;
    end else begin
      core_reset <= any_reset;
      wake <= 1'b0;
      pc_load <= 1'b0;
      stack_push <= 1'b0;
      if (any_reset) begin
        // reset vector load
        // a reset drops any pending interrupt vector
        pc_load <= 1'b1;
        pc_value <= RCR_RESET_VECTOR;
        vector_pend_reg <= 1'b0;
      end else if (wdt_wake || irq_wake) begin
        wake <= 1'b1;
        pc_load <= 1'b1;
        pc_value <= pc_step(pc_current, 2'h1);
        // return address is the instruction after the resumed one
        ret_addr_reg <= pc_step(pc_current, 2'h2);
        vector_pend_reg <= irq_wake && global_interrupt_enable;
      end else if (vector_pend_reg) begin
        pc_load <= 1'b1;
        pc_value <= RCR_IRQ_VECTOR;
        stack_push <= 1'b1;
        stack_push_addr <= ret_addr_reg;
        vector_pend_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // read data, captured in the setup phase
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= 32'h0000_0000;
      // unused bits and unmapped reads return zero
      unique case (sel)
        RCR_SEL_STATUS: begin
          prdata[RCR_ST_TIMEOUT] <= timeout_reg;
          prdata[RCR_ST_PDOWN] <= pdown_reg;
        end
        RCR_SEL_CAUSE0: prdata[7:0] <= cause0_reg;
        RCR_SEL_CAUSE1: prdata[RCR_C1_MEMVIO] <= memvio_reg;
        RCR_SEL_BORCTL: begin
          prdata[RCR_BC_SWEN] <= swen_reg;
          prdata[RCR_BC_RDY] <= brownout_circuit_active;
        end
        RCR_SEL_NONE: prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule // rcr_reset_cause_recorder

// ===== verif/rcr_monitor.sv
`timescale 1ns/100ps
module rcr_monitor #(
  parameter int PC_W = 15 // pc width
) (
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic psel, // apb
  input wire logic penable, // apb
  input wire logic pready, // apb
  input wire logic pslverr, // apb
  input wire logic sleeping, // asleep
  input wire logic ext_pin_event, // event
  input wire logic wdt_expire_event, // event
  input wire logic wdt_window_event, // event
  input wire logic reset_instr_event, // event
  input wire logic stack_overflow_event, // event
  input wire logic stack_underflow_event, // event
  input wire logic mem_violation_event, // event
  input wire logic interrupt_wake_event, // event
  input wire logic brownout_detect, // event
  input wire logic stack_fault_reset_enable, // level
  input wire logic global_interrupt_enable, // level
  input wire logic [1:0] brownout_config_field, // level
  input wire logic [PC_W-1:0] pc_current, // pc
  input wire logic core_reset, // pulse
  input wire logic wake, // pulse
  input wire logic pc_load, // pulse
  input wire logic [PC_W-1:0] pc_value, // pc
  input wire logic stack_push, // pulse
  input wire logic [PC_W-1:0] stack_push_addr, // addr
  input wire logic brownout_reset_enable // armed
);
  import rcr_pkg::*;
  // ----------------------------------------------------------------
  // event checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // any other reset source except the watchdog in the same cycle
  wire stk = stack_overflow_event | stack_underflow_event;
  wire oth = ext_pin_event | wdt_window_event | reset_instr_event | mem_violation_event | brownout_detect
    | (stack_fault_reset_enable & stk);
  sequence s_vec;
    pc_load && stack_push && pc_value == RCR_IRQ_VECTOR && stack_push_addr == $past(pc_current, 2) + 2'd2;
  endsequence
  AST_PIN_RST: assert property (ext_pin_event |=> core_reset && pc_load && pc_value == RCR_RESET_VECTOR)
    else $error("pin reset not taken");
  AST_WDT_WAKE: assert property (sleeping && wdt_expire_event && !oth |=>
    wake && !core_reset && pc_load && pc_value == $past(pc_current) + 1'b1) else $error("wdt wake wrong");
  AST_IRQ_VEC: assert property (sleeping && interrupt_wake_event && global_interrupt_enable && !oth
    && !wdt_expire_event |=> wake ##1 s_vec) else $error("irq vector wrong");
  AST_IRQ_AWAKE: assert property (!sleeping && interrupt_wake_event && !oth && !wdt_expire_event
    |=> !wake && !pc_load) else $error("irq wake while running");
  AST_STK_ON: assert property (stack_fault_reset_enable && stk |=> core_reset && pc_value == RCR_RESET_VECTOR)
    else $error("stack reset missing");
  AST_STK_OFF: assert property (!stack_fault_reset_enable && stk && !oth && !wdt_expire_event
    && !interrupt_wake_event |=> !core_reset) else $error("stack reset not gated");
  AST_BOR_OFF: assert property (brownout_config_field == RCR_BORCFG_OFF |-> !brownout_reset_enable)
    else $error("bor armed when off");
  AST_BOR_ON: assert property (brownout_config_field[1] |-> brownout_reset_enable)
    else $error("bor not armed");
  AST_APB_RDY: assert property (pslverr |-> psel && penable && pready)
    else $error("slverr outside access");
endmodule // rcr_monitor

bind rcr_reset_cause_recorder rcr_monitor #(.PC_W(PC_W)) u_mon (.pclk, .presetn, .psel, .penable, .pready,
  .pslverr, .sleeping, .ext_pin_event, .wdt_expire_event, .wdt_window_event, .reset_instr_event,
  .stack_overflow_event, .stack_underflow_event, .mem_violation_event, .interrupt_wake_event, .brownout_detect,
  .stack_fault_reset_enable, .global_interrupt_enable, .brownout_config_field, .pc_current, .core_reset, .wake,
  .pc_load, .pc_value, .stack_push, .stack_push_addr, .brownout_reset_enable);

// ===== verif/tb.sv
`timescale 1ns/100ps
module tb;
  import rcr_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, sleeping = 1'b0, bcact = 1'b1, sfen = 1'b1, gien = 1'b1;
  logic [1:0] bcfg = 2'h1;
  logic [8:0] ev = 9'h000;
  logic [14:0] pcc = 15'h0123;
  logic [14:0] pc_value, spa;
  logic core_reset, wake, pc_load, stack_push, bren;
  int miscompares = 0, cmp_count = 0, cyc = 0;
  // ----------------------------------------------------------------
  // clock, device, watchdog
  // ----------------------------------------------------------------
  always #2 pclk = ~pclk;
  rcr_reset_cause_recorder i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sleeping, .ext_pin_event(ev[0]), .brownout_detect(ev[8]),
    .brownout_circuit_active(bcact), .brownout_config_field(bcfg), .wdt_expire_event(ev[1]),
    .wdt_window_event(ev[2]), .reset_instr_event(ev[3]), .stack_overflow_event(ev[4]),
    .stack_underflow_event(ev[5]), .stack_fault_reset_enable(sfen), .mem_violation_event(ev[6]),
    .interrupt_wake_event(ev[7]), .global_interrupt_enable(gien), .pc_current(pcc), .core_reset,
    .wake, .pc_load, .pc_value, .stack_push, .stack_push_addr(spa), .brownout_reset_enable(bren));
  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      final_report;
    end
  end
  task automatic final_report;
    if (miscompares == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("[ERR] %s exp %h got %h", nm, e, g);
      miscompares++;
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, {24'h0, e}, rd);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  // one-cycle event pulse
  task automatic pulse(input int i);
    @(posedge pclk);
    ev[i] <= 1'b1;
    @(posedge pclk);
    ev <= 9'h000;
    repeat (3) @(posedge pclk);
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdc("status", RCR_OFS_STATUS, 8'h18);
    rdc("cause0", RCR_OFS_CAUSE0, 8'h3C);
    rdc("cause1", RCR_OFS_CAUSE1, 8'h02);
    rdc("borctl", RCR_OFS_BORCTL, 8'h81);
    chk("bren", 32'h1, {31'h0, bren});
    rdc("unmapped", 8'h10, 8'h00);
    chk("slverr", 32'h1, {31'h0, err});
    wr(RCR_OFS_STATUS, 8'h00);
    rdc("status_ro", RCR_OFS_STATUS, 8'h18);
    pulse(0);
    rdc("pin_run", RCR_OFS_CAUSE0, 8'h34);
    wr(RCR_OFS_CAUSE0, 8'hFF);
    pulse(3);
    rdc("rst_instr", RCR_OFS_CAUSE0, 8'hFB);
    pulse(1);
    rdc("wdt_rst", RCR_OFS_CAUSE0, 8'hEB);
    rdc("wdt_st", RCR_OFS_STATUS, 8'h08);
    pulse(2);
    rdc("window", RCR_OFS_CAUSE0, 8'hCB);
    wr(RCR_OFS_CAUSE0, 8'h00);
    pulse(4);
    rdc("ovf", RCR_OFS_CAUSE0, 8'h80);
    pulse(5);
    rdc("unf", RCR_OFS_CAUSE0, 8'hC0);
    wr(RCR_OFS_CAUSE0, 8'h00);
    sfen <= 1'b0;
    pulse(4);
    pulse(5);
    rdc("stk_off", RCR_OFS_CAUSE0, 8'h00);
    pulse(6);
    rdc("memviol", RCR_OFS_CAUSE1, 8'h00);
    sleeping <= 1'b1;
    pulse(1);
    rdc("wdt_wake", RCR_OFS_STATUS, 8'h00);
    chk("wake_pc", 32'h0000_0124, {17'h0, pc_value});
    pulse(0);
    rdc("pin_slp", RCR_OFS_STATUS, 8'h10);
    rdc("pin_slp1", RCR_OFS_CAUSE1, 8'h00);
    chk("pin_pc", 32'h0000_0000, {17'h0, pc_value});
    pulse(1);
    pulse(7);
    rdc("irq_wake", RCR_OFS_STATUS, 8'h10);
    chk("irq_vec", 32'h0000_0004, {17'h0, pc_value});
    chk("irq_ret", 32'h0000_0125, {17'h0, spa});
    sleeping <= 1'b0;
    pulse(7);
    rdc("irq_run", RCR_OFS_STATUS, 8'h10);
    wr(RCR_OFS_BORCTL, 8'h00);
    rdc("swen0", RCR_OFS_BORCTL, 8'h01);
    chk("bren0", 32'h0, {31'h0, bren});
    bcfg <= 2'h2;
    bcact <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("bren_cfg", 32'h1, {31'h0, bren});
    rdc("rdy0", RCR_OFS_BORCTL, 8'h00);
    wr(RCR_OFS_BORCTL, 8'h80);
    rdc("swen_rw", RCR_OFS_BORCTL, 8'h80);
    chk("bren_rw", 32'h1, {31'h0, bren});
    wr(RCR_OFS_CAUSE0, 8'h00);
    pulse(8);
    rdc("bor", RCR_OFS_CAUSE0, 8'h3C);
    bcfg <= 2'h0;
    wr(RCR_OFS_CAUSE0, 8'h00);
    pulse(8);
    rdc("bor_off", RCR_OFS_CAUSE0, 8'h00);
    bcfg <= 2'h1;
    repeat (2) @(posedge pclk);
    chk("bren1", 32'h1, {31'h0, bren});
    final_report;
  end
endmodule // tb
